// file: hdl/adc_sequencer_control.sv
// Successive-approximation converter control with registers and sequencer.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_control (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic sleep_active,
    input wire logic comparator_high,
    output logic [3:0] input_select,
    output logic sample_connect,
    output logic neg_reference_select,
    output logic pos_reference_select,
    output logic [adc_seq_pkg::CHANNELS-1:0] pin_analog_config,
    output logic [adc_seq_pkg::RESULT_BITS-1:0] trial_code,
    output logic conversion_done_flag
);
    import adc_seq_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] control_reg, config_reg, timing_reg, rdata_reg;
    logic [7:0] result_high_reg, result_low_reg;
    logic done_reg, run_reg;
    logic [RESULT_BITS-1:0] sar_reg;
    logic [3:0] bit_reg;
    logic [4:0] acq_reg;
    logic [7:0] div_reg, delay_reg;
    logic tick_reg, sample_reg;
    logic [CHANNELS-1:0] analog_reg;
    seq_state_e state_reg;

    // Register decode and field extraction.
    wire wr_control = reg_write && reg_addr == ADDR_CONTROL;
    wire wr_config = reg_write && reg_addr == ADDR_CONFIG;
    wire wr_timing = reg_write && reg_addr == ADDR_TIMING;
    wire wr_status = reg_write && reg_addr == ADDR_STATUS;
    wire power_on = control_reg[POWER_BIT];
    // Enable as it will stand after this edge, so one write can start.
    wire power_next = wr_control ? reg_wdata[POWER_BIT] : power_on;
    wire [2:0] clk_sel = timing_reg[CLK_SEL_MSB:0];
    wire [2:0] acq_sel = timing_reg[ACQ_MSB:ACQ_LSB];
    wire rc_clock = clk_sel[1] && clk_sel[0];
    // A start needs the enable bit set in the same write as the run bit.
    wire start_req = wr_control && reg_wdata[RUN_BIT] &&
        reg_wdata[POWER_BIT] && state_reg == S_IDLE;
    wire busy = state_reg != S_IDLE;

    // Half period of the divided oscillator clock in system clocks.
    logic [7:0] half_div;
    always_comb begin
        unique case (clk_sel)
            3'h0: half_div = 8'h01;
            3'h1: half_div = 8'h04;
            3'h2: half_div = 8'h10;
            3'h4: half_div = 8'h02;
            3'h5: half_div = 8'h08;
            3'h6: half_div = 8'h20;
            default: half_div = RC_HALF;
        endcase
    end

    // Acquisition length in conversion clock periods.
    logic [4:0] acq_len;
    always_comb begin
        unique case (acq_sel)
            3'h0: acq_len = 5'h00;
            3'h1: acq_len = 5'h02;
            3'h2: acq_len = 5'h04;
            3'h3: acq_len = 5'h06;
            3'h4: acq_len = 5'h08;
            3'h5: acq_len = 5'h0c;
            3'h6: acq_len = 5'h10;
            default: acq_len = 5'h14;
        endcase
    end

    // Oscillator clocks stop in sleep; the RC clock keeps running.
    wire clock_runs = rc_clock || !sleep_active;
    wire [7:0] period = {half_div[6:0], 1'b0};
    wire div_wrap = div_reg + 8'h01 >= period;

    // Port configuration: code n above 3 makes the top n-3 pins digital.
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_pin
            localparam logic [3:0] THRESH = 4'(CHANNELS + 3 - g);
            assign pin_analog_config[g] = analog_reg[g];
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) analog_reg[g] <= 1'b1;
                else analog_reg[g] <= config_reg[PIN_CFG_MSB:0] < THRESH ||
                    config_reg[PIN_CFG_MSB:0] <= ALL_ANALOG_LAST;
            end
        end
    endgenerate

    // Read multiplexer; unimplemented bits are masked to zero.
    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            ADDR_CONTROL: rd_mux = control_reg;
            ADDR_CONFIG: rd_mux = config_reg;
            ADDR_TIMING: rd_mux = timing_reg;
            ADDR_RESULT_HIGH: rd_mux = result_high_reg;
            ADDR_RESULT_LOW: rd_mux = result_low_reg;
            ADDR_STATUS: rd_mux = {7'h00, done_reg};
            default: rd_mux = RESET_VALUE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers; reset returns all to their reset values.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            config_reg <= RESET_VALUE;
            timing_reg <= RESET_VALUE;
        end else begin
            if (wr_config) config_reg <= reg_wdata & CONFIG_MASK;
            if (wr_timing) timing_reg <= reg_wdata & TIMING_MASK;
        end
    end

    // Control register; run bit mirrors the sequencer, not the write.
    wire [7:0] control_next = {2'b00, (wr_control ?
        reg_wdata[SEL_MSB:SEL_LSB] : control_reg[SEL_MSB:SEL_LSB]),
        run_reg, (wr_control ? reg_wdata[POWER_BIT] : power_on)};
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) control_reg <= RESET_VALUE;
        else control_reg <= control_next;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) rdata_reg <= RESET_VALUE;
        else rdata_reg <= reg_read ? rd_mux : RESET_VALUE;
    end
    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Conversion clock: divider makes one tick per clock period.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else if (state_reg == S_IDLE || state_reg == S_WAIT ||
                     !clock_runs) begin
            div_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_wrap ? 8'h00 : div_reg + 8'h01;
            tick_reg <= div_wrap;
        end
    end

    // Sequencer: start, optional RC delay, optional acquisition, eleven periods.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= S_IDLE;
            run_reg <= 1'b0;
            delay_reg <= 8'h00;
            acq_reg <= 5'h00;
            bit_reg <= 4'h0;
            sar_reg <= '0;
            sample_reg <= 1'b1;
        end else if (!power_next) begin
            // Clearing the enable aborts at the very edge of the write.
            state_reg <= S_IDLE;
            run_reg <= 1'b0;
            sample_reg <= 1'b1;
        end else begin
            unique case (state_reg)
                S_IDLE: if (start_req) begin
                    run_reg <= 1'b1;
                    delay_reg <= rc_clock ? INSTR_DELAY : 8'h00;
                    acq_reg <= acq_len;
                    state_reg <= S_WAIT;
                end
                S_WAIT: if (delay_reg == 8'h00) begin
                    state_reg <= acq_reg == 5'h00 ? S_CONV : S_ACQ;
                    sample_reg <= acq_reg != 5'h00;
                    bit_reg <= 4'h0;
                    sar_reg <= '0;
                end else delay_reg <= delay_reg - 8'h01;
                S_ACQ: if (tick_reg) begin
                    if (acq_reg == 5'h01) begin
                        state_reg <= S_CONV;
                        sample_reg <= 1'b0;
                    end
                    acq_reg <= acq_reg - 5'h01;
                end
                S_CONV: if (tick_reg) begin
                    // First period settles the hold, then one bit per period.
                    if (bit_reg != 4'h0)
                        sar_reg[RESULT_BITS - int'(bit_reg)] <=
                            comparator_high;
                    if (bit_reg == CONVERT_PERIODS - 4'h1) begin
                        state_reg <= S_IDLE;
                        run_reg <= 1'b0;
                        sample_reg <= 1'b1;
                    end
                    bit_reg <= bit_reg + 4'h1;
                end
            endcase
        end
    end

    // Trial code tests the current bit on top of those resolved so far.
    wire [RESULT_BITS-1:0] trial_bit = (bit_reg == 4'h0) ? '0 :
        RESULT_BITS'(1) << (RESULT_BITS - int'(bit_reg));
    wire finishing = state_reg == S_CONV && tick_reg &&
        bit_reg == CONVERT_PERIODS - 4'h1;
    wire [RESULT_BITS-1:0] final_code = {sar_reg[RESULT_BITS-1:1],
        comparator_high};

    // Results and done flag; the flag set wins over a software clear.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            result_high_reg <= RESET_VALUE;
            result_low_reg <= RESET_VALUE;
            done_reg <= 1'b0;
        end else begin
            if (finishing) begin
                done_reg <= 1'b1;
                if (timing_reg[JUSTIFY_BIT]) begin
                    result_high_reg <= {6'h00, final_code[9:8]};
                    result_low_reg <= final_code[7:0];
                end else begin
                    result_high_reg <= final_code[9:2];
                    result_low_reg <= {final_code[1:0], 6'h00};
                end
            end else if (wr_status && !reg_wdata[0]) done_reg <= 1'b0;
        end
    end

    // Analog side outputs, all registered.
    logic [3:0] sel_reg;
    logic neg_reg, pos_reg;
    logic [RESULT_BITS-1:0] trial_reg;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_reg <= 4'h0;
            neg_reg <= 1'b0;
            pos_reg <= 1'b0;
            trial_reg <= '0;
        end else begin
            // Codes above 11 pass through and leave the sampler floating.
            sel_reg <= control_reg[SEL_MSB:SEL_LSB];
            neg_reg <= config_reg[NEG_REF_BIT];
            pos_reg <= config_reg[POS_REF_BIT];
            trial_reg <= sar_reg | trial_bit;
        end
    end
    assign input_select = sel_reg;
    assign neg_reference_select = neg_reg;
    assign pos_reference_select = pos_reg;
    assign trial_code = trial_reg;
    assign sample_connect = sample_reg;
    assign conversion_done_flag = done_reg;

    ////////////////////////////////////////////////////////////////////////
    // Count of conversion periods between start of conversion and done.
    logic [4:0] conv_ticks;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) conv_ticks <= 5'h00;
        else if (state_reg != S_CONV) conv_ticks <= 5'h00;
        else if (tick_reg) conv_ticks <= conv_ticks + 5'h01;
    end

    // Ticks spent sampling, checked against the programmed acquisition.
    logic [4:0] acq_ticks;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) acq_ticks <= 5'h00;
        else if (state_reg != S_ACQ) acq_ticks <= 5'h00;
        else if (tick_reg) acq_ticks <= acq_ticks + 5'h01;
    end

    eleven_periods_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $fell(run_reg) && power_on |-> $past(conv_ticks) == 5'h0a)
        else $error("conversion did not take eleven periods");
    done_clears_run_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n) finishing |=> !run_reg && done_reg)
        else $error("end of conversion did not clear run and set flag");
    disabled_no_run_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n) !power_next |=> !run_reg)
        else $error("run bit set while module off");
    run_matches_busy_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n) run_reg == busy)
        else $error("run bit disagrees with sequencer");
    start_sets_run_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n) start_req |=> run_reg)
        else $error("start did not set run bit");
    unused_bits_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        control_reg[7:6] == 2'b00 && config_reg[7:6] == 2'b00)
        else $error("unimplemented bits read nonzero");
    sample_resumes_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n) finishing |=> sample_reg)
        else $error("sampling did not resume");
    rc_delay_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        start_req && rc_clock |=> state_reg == S_WAIT [*4])
        else $error("RC clock start not delayed");
    right_justify_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n) finishing && timing_reg[JUSTIFY_BIT]
        |=> result_high_reg[7:2] == 6'h00)
        else $error("right justified high bits nonzero");

    // Outputs toward the analog side follow their fields one cycle late.
    select_follows_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        sel_reg == $past(control_reg[SEL_MSB:SEL_LSB]))
        else $error("channel output does not follow its field");
    refs_follow_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        {neg_reg, pos_reg} == $past({config_reg[NEG_REF_BIT],
        config_reg[POS_REF_BIT]}))
        else $error("reference outputs do not follow their bits");
    pins_analog_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        config_reg[PIN_CFG_MSB:0] <= ALL_ANALOG_LAST |=> &analog_reg)
        else $error("low port code left a pin digital");
    pins_digital_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        &config_reg[PIN_CFG_MSB:0] |=> analog_reg == '0)
        else $error("top port code left a pin analog");

    // The hold opens only for conversion; acquisition keeps sampling.
    hold_in_conv_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        state_reg == S_CONV |-> !sample_reg)
        else $error("sampler connected during conversion");
    acq_samples_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        state_reg == S_ACQ |-> sample_reg)
        else $error("sampler open during acquisition");
    acq_length_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        state_reg == S_ACQ && tick_reg && acq_reg == 5'h01
        |-> acq_ticks + 5'h01 == acq_len)
        else $error("acquisition length differs from its code");

    // Sleep stalls the divided clock; disable and flag clear take effect.
    sleep_stall_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        sleep_active && !rc_clock |=> !tick_reg)
        else $error("divided clock ran during sleep");
    off_aborts_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !power_next |=> state_reg == S_IDLE)
        else $error("disable did not abort the sequencer");
    flag_clear_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        wr_status && !reg_wdata[0] && !finishing |=> !done_reg)
        else $error("software clear of done flag was lost");
endmodule // adc_sequencer_control
`default_nettype wire

// file: hdl/adc_seq_pkg.sv
// Package of register map, field positions and timing constants for the converter control.
package adc_seq_pkg;
    // Register indices on the plain register port.
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_CONFIG = 3'h1;
    localparam logic [2:0] ADDR_TIMING = 3'h2;
    localparam logic [2:0] ADDR_RESULT_HIGH = 3'h3;
    localparam logic [2:0] ADDR_RESULT_LOW = 3'h4;
    localparam logic [2:0] ADDR_STATUS = 3'h5;
    // Field positions.
    localparam int POWER_BIT = 0;
    localparam int RUN_BIT = 1;
    localparam int SEL_LSB = 2;
    localparam int SEL_MSB = 5;
    localparam int PIN_CFG_MSB = 3;
    localparam int POS_REF_BIT = 4;
    localparam int NEG_REF_BIT = 5;
    localparam int CLK_SEL_MSB = 2;
    localparam int ACQ_LSB = 3;
    localparam int ACQ_MSB = 5;
    localparam int JUSTIFY_BIT = 7;
    // Writable masks; unimplemented bits read zero.
    localparam logic [7:0] CONTROL_MASK = 8'h3f;
    localparam logic [7:0] CONFIG_MASK = 8'h3f;
    localparam logic [7:0] TIMING_MASK = 8'hbf;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // Channel and port limits.
    localparam logic [3:0] LAST_CHANNEL = 4'hb;
    localparam logic [3:0] ALL_ANALOG_LAST = 4'h3;
    localparam int CHANNELS = 12;
    localparam int RESULT_BITS = 10;
    // Conversion takes eleven clock periods; the first clears the hold.
    localparam logic [3:0] CONVERT_PERIODS = 4'hb;
    // Rates of the dedicated RC clock and of the instruction cycle.
    localparam int SYS_CLK_HZ = 20000000;
    localparam int RC_PERIOD_NS = 4000;
    localparam int INSTR_OSC_PERIODS = 4;
    localparam int SYS_PERIOD_NS = 1000000000 / SYS_CLK_HZ;
    localparam int RC_HALF_CYCLES = RC_PERIOD_NS / SYS_PERIOD_NS / 2;
    localparam logic [7:0] RC_HALF = 8'(RC_HALF_CYCLES);
    localparam logic [7:0] INSTR_DELAY = 8'(INSTR_OSC_PERIODS);
    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_ACQ, S_CONV} seq_state_e;
endpackage

// file: testbench/adc_sequencer_control_test.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_control_test;
    import adc_seq_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic sleep_active = 1'b0;
    logic comparator_high;
    logic [7:0] reg_rdata;
    logic [3:0] input_select;
    logic sample_connect;
    logic neg_reference_select;
    logic pos_reference_select;
    logic [CHANNELS-1:0] pin_analog_config;
    logic [RESULT_BITS-1:0] trial_code;
    logic conversion_done_flag;
    logic [9:0] analog_level = 10'h000;
    int errors = 0;
    int comparisons = 0;

    adc_sequencer_control adc_sequencer_control_inst (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .sleep_active(sleep_active),
        .comparator_high(comparator_high), .input_select(input_select),
        .sample_connect(sample_connect),
        .neg_reference_select(neg_reference_select),
        .pos_reference_select(pos_reference_select),
        .pin_analog_config(pin_analog_config), .trial_code(trial_code),
        .conversion_done_flag(conversion_done_flag)
    );

    ////////////////////////////////////////////////////////////////////////
    // The clock toggles every 25 ns, half of its 50 ns period.
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // The comparator is analog and answers the registered trial at once;
    // a further lag here would miss the two-clock bit period.
    assign comparator_high = (analog_level >= trial_code);

    ////////////////////////////////////////////////////////////////////////
    // Comparison, bus cycles and expectation helpers.
    task automatic chk(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample then.
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Waits for the done flag under a bound; notes whether the hold opened.
    task automatic wait_done(input int lim, output int n, output logic held);
        n = 0;
        held = 1'b0;
        while (conversion_done_flag !== 1'b1 && n < lim) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (sample_connect === 1'b0) held = 1'b1;
        end
    endtask

    function automatic int div_of(input logic [2:0] c);
        case (c)
            3'h0: return 2;
            3'h1: return 8;
            3'h2: return 32;
            3'h4: return 4;
            3'h5: return 16;
            3'h6: return 64;
            default: return 80;
        endcase
    endfunction

    function automatic int acq_of(input logic [2:0] c);
        int t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
        return t[c];
    endfunction

    function automatic logic [11:0] pins_of(input logic [3:0] c);
        return (c <= 4'h3) ? 12'hfff : (12'hfff >> (c - 4'h3));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Ends the run with the counts and the verdict.
    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // A hang is cut short well past the longest expected run.
    initial begin
        repeat (60000) @(posedge sys_clk);
        errors++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        logic [7:0] d;
        logic [7:0] hi;
        logic [2:0] ck;
        logic [3:0] ch;
        logic j;
        logic held;
        int n;
        int seed;
        int lo_b;
        int hi_b;
        seed = $urandom(32'he569);
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), d);
            chk("reset_read", d, 16'h0);
        end
        chk("pins_reset", pin_analog_config, 12'hfff);
        wr(ADDR_CONTROL, 8'hfc);
        rd(ADDR_CONTROL, d);
        chk("control_mask", d, 8'h3c);
        chk("floating_select", input_select, 4'hf);
        wr(ADDR_CONTROL, 8'h02);
        rd(ADDR_CONTROL, d);
        chk("run_while_off", d, 8'h00);
        // Every port code, with random reference bits and dead bits set.
        for (int c = 0; c < 16; c++) begin
            d = {2'b11, 2'($urandom), 4'(c)};
            wr(ADDR_CONFIG, d);
            rd(ADDR_CONFIG, hi);
            chk("config_read", hi, d & 8'h3f);
            chk("pins", pin_analog_config, pins_of(4'(c)));
            chk("neg_ref", neg_reference_select, d[5]);
            chk("pos_ref", pos_reference_select, d[4]);
        end
        // Every clock code, each with its own acquisition code.
        for (int k = 0; k < 8; k++) begin
            ck = 3'(k);
            j = 1'($urandom);
            if (k < 2) j = 1'(k);
            ch = 4'($urandom);
            analog_level = 10'($urandom);
            if (k == 0) analog_level = 10'h3ff;
            @(posedge sys_clk);
            sleep_active <= (ck[1:0] == 2'b11);
            wr(ADDR_TIMING, {j, 1'b1, ck, ck});
            rd(ADDR_TIMING, d);
            chk("timing_read", d, {j, 1'b0, ck, ck});
            wr(ADDR_CONTROL, {2'b00, ch, 2'b11});
            wait_done(4000, n, held);
            lo_b = (acq_of(ck) + 10) * div_of(ck);
            hi_b = (acq_of(ck) + 12) * div_of(ck) + 8;
            chk("conv_cycles", 16'(n >= lo_b && n <= hi_b), 16'h1);
            chk("input_select", input_select, ch);
            chk("held_sample", held, 1'b1);
            rd(ADDR_CONTROL, d);
            chk("run_cleared", d, {2'b00, ch, 2'b01});
            chk("resample", sample_connect, 1'b1);
            rd(ADDR_RESULT_HIGH, hi);
            rd(ADDR_RESULT_LOW, d);
            chk("result", {hi, d}, j ? {6'h0, analog_level}
                : {analog_level, 6'h0});
            rd(ADDR_STATUS, d);
            chk("done_flag", d, 8'h01);
            wr(ADDR_STATUS, 8'h00);
            rd(ADDR_STATUS, d);
            chk("flag_clear", d, 8'h00);
            repeat (3 * div_of(ck)) @(posedge sys_clk);
        end
        // The divided oscillator stops in sleep, so conversion stalls.
        @(posedge sys_clk);
        sleep_active <= 1'b1;
        wr(ADDR_TIMING, 8'h00);
        wr(ADDR_CONTROL, 8'h07);
        repeat (200) @(posedge sys_clk);
        rd(ADDR_CONTROL, d);
        chk("busy_in_sleep", d, 8'h07);
        chk("stall_in_sleep", conversion_done_flag, 1'b0);
        @(posedge sys_clk);
        sleep_active <= 1'b0;
        wait_done(100, n, held);
        chk("wake_finish", conversion_done_flag, 1'b1);
        // Switching the module off aborts a conversion.
        wr(ADDR_STATUS, 8'h00);
        wr(ADDR_TIMING, 8'h06);
        wr(ADDR_CONTROL, 8'h03);
        repeat (100) @(posedge sys_clk);
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_CONTROL, d);
        chk("off_abort", d, 8'h00);
        repeat (1000) @(posedge sys_clk);
        chk("off_no_flag", conversion_done_flag, 1'b0);
        wr(ADDR_CONTROL, 8'h01);
        rd(ADDR_CONTROL, d);
        chk("idle_run", d, 8'h01);
        // Reset in mid conversion restores everything.
        wr(ADDR_CONTROL, 8'h03);
        repeat (100) @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(ADDR_CONTROL, d);
        chk("reset_control", d, 8'h00);
        rd(ADDR_TIMING, d);
        chk("reset_timing", d, 8'h00);
        repeat (1500) @(posedge sys_clk);
        chk("reset_no_flag", conversion_done_flag, 1'b0);
        close_out();
    end
endmodule // adc_sequencer_control_test
`default_nettype wire
